// file: logic/ocs_serial_ctrl.sv
// serial control and fault report logic of an eight channel switch
`timescale 1ns/10ps
`include "ocs_cfg.svh"
module ocs_serial_ctrl
#(
	parameter int DEPTH = 2,
	parameter int FAULT_CYC = `OCS_FAULT_CYC
)
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_chip_sel_n,
	input wire logic i_serial_clk,
	input wire logic i_serial_cmd_in,
	input wire logic i_enable,
	input wire logic i_direct_drive_five,
	input wire logic i_direct_drive_six,
	input wire logic [`OCS_CH-1:0] i_fault_cond,
	output logic o_serial_out,
	output logic o_serial_out_oe,
	output logic [`OCS_CH-1:0] o_drive,
	output logic [`OCS_CH-1:0] o_olc_en,
	output logic o_sleep,
	output logic o_cmd_ready
);
	import ocs_pkg::*;
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int FW = $clog2(FAULT_CYC + 1);

	function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
		next_ptr = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	// synchronisers reset to idle pin levels; s1_q is read by s2_q only
	ocs_pin_t s1_q, s2_q;
	logic prev_cs_q, prev_sclk_q;
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			s1_q <= '{cs_n: 1'b1, default: '0};
			s2_q <= '{cs_n: 1'b1, default: '0};
			prev_cs_q <= 1'b1;
			prev_sclk_q <= 1'b0;
		end
		else
		begin
			s1_q <= '{i_chip_sel_n, i_serial_clk, i_serial_cmd_in, i_enable,
				i_direct_drive_five, i_direct_drive_six, i_fault_cond};
			s2_q <= s1_q;
			prev_cs_q <= s2_q.cs_n;
			prev_sclk_q <= s2_q.sclk;
		end
	end

	logic en, cs_lo, cs_rise, cs_fall, sclk_rise, sclk_fall;
	assign en = s2_q.en;
	assign cs_lo = !s2_q.cs_n;
	assign cs_rise = s2_q.cs_n && !prev_cs_q;
	assign cs_fall = !s2_q.cs_n && prev_cs_q;
	assign sclk_rise = s2_q.sclk && !prev_sclk_q;
	assign sclk_fall = !s2_q.sclk && prev_sclk_q;
	// serial shifter and status return
	logic [`OCS_FRAME_BITS-1:0] sh_q, sh_d;
	logic [`OCS_FRAME_BITS-1:0] osh_q, osh_d;
	logic [`OCS_BCNT_W-1:0] bcnt_q, bcnt_d;
	logic sdo_q, sdo_d;
	logic oe_q, oe_d;
	logic [`OCS_CH-1:0] status_q, status_d;
	always_comb
	begin
		sh_d = sh_q;
		osh_d = osh_q;
		bcnt_d = bcnt_q;
		sdo_d = sdo_q;
		oe_d = 1'b0;
		if (!en)
		begin
			sh_d = '0;
			osh_d = '0;
			bcnt_d = '0;
			sdo_d = 1'b0;
		end
		else
		begin
			oe_d = cs_lo;
			if (cs_fall)
			begin
				bcnt_d = '0;
				osh_d = {{`OCS_CH{1'b0}}, status_q};
				sdo_d = 1'b0;
			end
			else if (cs_lo)
			begin
				if (sclk_fall)
				begin
					sh_d = {sh_q[`OCS_FRAME_BITS-2:0], s2_q.din};
					if (bcnt_q != '1)
						bcnt_d = bcnt_q + 1'b1;
				end
				if (sclk_rise)
				begin
					sdo_d = osh_q[`OCS_FRAME_BITS-1];
					osh_d = {osh_q[`OCS_FRAME_BITS-2:0], 1'b0};
				end
			end
		end
	end
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			sh_q <= '0;
			osh_q <= '0;
			bcnt_q <= '0;
			sdo_q <= 1'b0;
			oe_q <= 1'b0;
		end
		else
		begin
			sh_q <= sh_d;
			osh_q <= osh_d;
			bcnt_q <= bcnt_d;
			sdo_q <= sdo_d;
			oe_q <= oe_d;
		end
	end
	assign o_serial_out = sdo_q;
	assign o_serial_out_oe = oe_q;

	// a short or long frame is dropped rather than applied half-filled
	logic push, push_ok;
	assign push = en && cs_rise &&
		bcnt_q == `OCS_BCNT_W'(`OCS_FRAME_BITS);
	// command buffer and apply stage
	ocs_cmd_t mem_q [DEPTH];
	ocs_cmd_t mem_d [DEPTH];
	logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [PW:0] cnt_q, cnt_d;
	logic rdy_q, rdy_d;
	ocs_state_t st_q, st_d;
	logic [`OCS_LAT_W-1:0] tmr_q, tmr_d;
	ocs_cmd_t pend_q, pend_d;
	ocs_cmd_t cmd_q, cmd_d;
	logic pop;
	assign push_ok = push && cnt_q != (PW+1)'(DEPTH);
	assign pop = st_q == OCS_IDLE && cnt_q != '0;
	always_comb
	begin
		mem_d = mem_q;
		wp_d = wp_q;
		rp_d = rp_q;
		cnt_d = cnt_q;
		st_d = st_q;
		tmr_d = tmr_q;
		pend_d = pend_q;
		cmd_d = cmd_q;
		if (push_ok)
		begin
			mem_d[wp_q] = '{olc: sh_q[`OCS_FRAME_BITS-1:`OCS_CH],
				on: sh_q[`OCS_CH-1:0]};
			wp_d = next_ptr(wp_q);
		end
		if (pop)
		begin
			pend_d = mem_q[rp_q];
			rp_d = next_ptr(rp_q);
			st_d = OCS_WAIT;
			// a channel dropping out takes the turn-off latency
			if (|(cmd_q.on & ~mem_q[rp_q].on))
				tmr_d = `OCS_LAT_W'(`OCS_TURN_OFF_CYC - 1);
			else
				tmr_d = `OCS_LAT_W'(`OCS_TURN_ON_CYC - 1);
		end
		else if (st_q == OCS_WAIT)
		begin
			if (tmr_q == '0)
			begin
				cmd_d = pend_q;
				st_d = OCS_IDLE;
			end
			else
				tmr_d = tmr_q - 1'b1;
		end
		cnt_d = cnt_q + (PW+1)'(push_ok) - (PW+1)'(pop);
		if (!en)
		begin
			wp_d = '0;
			rp_d = '0;
			cnt_d = '0;
			st_d = OCS_IDLE;
			tmr_d = '0;
			cmd_d = '0;
		end
		rdy_d = cnt_d != (PW+1)'(DEPTH);
	end
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			for (int k = 0; k < DEPTH; k++)
				mem_q[k] <= '0;
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			rdy_q <= 1'b0;
			st_q <= OCS_IDLE;
			tmr_q <= '0;
			pend_q <= '0;
			cmd_q <= '0;
		end
		else
		begin
			mem_q <= mem_d;
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
			rdy_q <= rdy_d;
			st_q <= st_d;
			tmr_q <= tmr_d;
			pend_q <= pend_d;
			cmd_q <= cmd_d;
		end
	end
	assign o_cmd_ready = rdy_q;
	// fault qualification, one counter per channel
	logic [`OCS_CH-1:0] qual;
	genvar g;
	generate
		for (g = 0; g < `OCS_CH; g++)
		begin : g_flt
			logic [FW-1:0] fc_q, fc_d;
			assign qual[g] = fc_q == FW'(FAULT_CYC);
			always_comb
			begin
				fc_d = fc_q;
				if (!en || !s2_q.fault[g])
					fc_d = '0;
				else if (!qual[g])
					fc_d = fc_q + 1'b1;
			end
			always_ff @(posedge i_clk)
			begin
				if (i_rst)
					fc_q <= '0;
				else
					fc_q <= fc_d;
			end
		end
	endgenerate

	// output drive
	logic [`OCS_CH-1:0] drv_q, drv_d, olc_q, olc_d, dir;
	logic slp_q, slp_d;
	always_comb
	begin
		dir = '0;
		dir[`OCS_OUT5_BIT] = s2_q.d5;
		dir[`OCS_OUT6_BIT] = s2_q.d6;
		drv_d = en ? (cmd_q.on | dir) : '0;
		olc_d = en ? cmd_q.olc : '0;
		slp_d = !en;
		// an off output with no test current cannot see a fault
		status_d = qual & (drv_q | olc_q);
	end
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			drv_q <= '0;
			olc_q <= '0;
			slp_q <= 1'b1;
			status_q <= '0;
		end
		else
		begin
			drv_q <= drv_d;
			olc_q <= olc_d;
			slp_q <= slp_d;
			status_q <= status_d;
		end
	end
	assign o_drive = drv_q;
	assign o_olc_en = olc_q;
	assign o_sleep = slp_q;

	AST_DO_FLOAT: assert property (@(posedge i_clk) disable iff (i_rst)
		s2_q.cs_n |=> !o_serial_out_oe)
		else $error("serial out driven while deselected");
	AST_DO_DRIVE: assert property (@(posedge i_clk) disable iff (i_rst)
		(en && cs_lo) |=> o_serial_out_oe)
		else $error("serial out not driven while selected");
	AST_SHIFT_IN: assert property (@(posedge i_clk) disable iff (i_rst)
		(en && cs_lo && !cs_fall && sclk_fall) |=> sh_q[0] == $past(s2_q.din))
		else $error("input bit not shifted on falling clock");
	AST_DO_ADV: assert property (@(posedge i_clk) disable iff (i_rst)
		(en && cs_lo && !cs_fall && sclk_rise)
		|=> o_serial_out == $past(osh_q[`OCS_FRAME_BITS-1]))
		else $error("serial out not advanced on rising clock");
	AST_PUSH_EDGE: assert property (@(posedge i_clk) disable iff (i_rst)
		push_ok |-> (cs_rise && bcnt_q == `OCS_BCNT_W'(`OCS_FRAME_BITS))
		##1 mem_q[$past(wp_q)] == $past(sh_q))
		else $error("command taken outside a full frame end");
	AST_APPLY_MIN: assert property (@(posedge i_clk) disable iff (i_rst)
		(en && $rose(st_q == OCS_WAIT)) |-> (en && st_q == OCS_WAIT)[*8]
		or ##[1:8] !en)
		else $error("command applied too early");
	AST_APPLY_MAX: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(st_q == OCS_WAIT) |-> ##[1:200] st_q == OCS_IDLE)
		else $error("command not applied in time");
	AST_APPLY_VAL: assert property (@(posedge i_clk) disable iff (i_rst)
		(en && st_q == OCS_WAIT && tmr_q == '0) ##1 en
		|-> ##1 o_drive[`OCS_CH-1:`OCS_OUT6_BIT+1] ==
		$past(pend_q.on[`OCS_CH-1:`OCS_OUT6_BIT+1], 2))
		else $error("drive does not follow applied command");
	AST_FAULT_QUAL: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(qual[`OCS_CH-1]) |-> $past(s2_q.fault[`OCS_CH-1]) &&
		$past(g_flt[`OCS_CH-1].fc_q) == FW'(FAULT_CYC - 1))
		else $error("fault qualified at wrong time");
	AST_STATUS_LOAD: assert property (@(posedge i_clk) disable iff (i_rst)
		(en && cs_fall) |=> osh_q == {{`OCS_CH{1'b0}}, $past(status_q)})
		else $error("status frame not loaded at select");
	AST_SLEEP: assert property (@(posedge i_clk) disable iff (i_rst)
		!en |=> o_drive == '0 && o_olc_en == '0 && o_sleep)
		else $error("outputs active while disabled");
	AST_WAKE_CLEAR: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(en) |-> cmd_q == '0 && cnt_q == '0)
		else $error("command latch not cleared on wake");
	AST_DIRECT: assert property (@(posedge i_clk) disable iff (i_rst)
		en |=> o_drive[`OCS_OUT5_BIT] ==
		($past(cmd_q.on[`OCS_OUT5_BIT]) | $past(s2_q.d5)))
		else $error("output five ignores direct drive");
	CV_FRAME: cover property (@(posedge i_clk) disable iff (i_rst) push_ok);
	CV_FULL: cover property (@(posedge i_clk) disable iff (i_rst)
		cnt_q == (PW+1)'(DEPTH));
	CV_FAULT: cover property (@(posedge i_clk) disable iff (i_rst)
		|status_q);
	CV_APPLY: cover property (@(posedge i_clk) disable iff (i_rst)
		st_q == OCS_WAIT ##1 st_q == OCS_IDLE);
endmodule

// file: inc/ocs_cfg.svh
// constants for the octal switch serial control port
`ifndef OCS_CFG_SVH
`define OCS_CFG_SVH
`define OCS_CH 8
`define OCS_FRAME_BITS 16
`define OCS_BCNT_W 5
`define OCS_LAT_W 8
`define OCS_OUT5_BIT 4
`define OCS_OUT6_BIT 5
`define OCS_CLK_PERIOD_NS 8
`define OCS_TURN_ON_LATENCY_NS 1000
`define OCS_TURN_OFF_LATENCY_NS 1000
`define OCS_FAULT_QUALIFY_TIME_US 100
`define OCS_TURN_ON_CYC ((`OCS_TURN_ON_LATENCY_NS + \
	`OCS_CLK_PERIOD_NS - 1) / `OCS_CLK_PERIOD_NS)
`define OCS_TURN_OFF_CYC ((`OCS_TURN_OFF_LATENCY_NS + \
	`OCS_CLK_PERIOD_NS - 1) / `OCS_CLK_PERIOD_NS)
`define OCS_FAULT_CYC ((`OCS_FAULT_QUALIFY_TIME_US * 1000 + \
	`OCS_CLK_PERIOD_NS - 1) / `OCS_CLK_PERIOD_NS)
`endif

// file: inc/ocs_pkg.sv
// types shared by the octal switch serial control port
package ocs_pkg;
`include "ocs_cfg.svh"
	typedef struct packed
	{
		logic [`OCS_CH-1:0] olc;
		logic [`OCS_CH-1:0] on;
	} ocs_cmd_t;
	typedef struct packed
	{
		logic cs_n;
		logic sclk;
		logic din;
		logic en;
		logic d5;
		logic d6;
		logic [`OCS_CH-1:0] fault;
	} ocs_pin_t;
	typedef enum logic [0:0] {OCS_IDLE, OCS_WAIT} ocs_state_t;
endpackage

// file: dv/ocs_host.sv
// host side model that drives the serial control pins
`timescale 1ns/10ps
module ocs_host
(
	input wire logic i_clk,
	input wire logic i_dout,
	input wire logic i_dout_oe,
	output logic o_cs_n,
	output logic o_sclk,
	output logic o_din
);
	initial
	begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_din = 1'b0;
	end
	// top n bits go out msb first, 32 ns half period
	// the link runs faster here than the usual host rate
	task automatic xfer(input logic [15:0] cmd, input int n,
		output logic [15:0] rsp);
		rsp = 16'h0000;
		@(posedge i_clk);
		#1;
		o_cs_n = 1'b0;
		#100;
		for (int i = 0; i < n; i++)
		begin
			o_din = cmd[15 - i];
			o_sclk = 1'b1;
			#32;
			o_sclk = 1'b0;
			#31;
			// a floating serial out must never read as data
			rsp = {rsp[14:0], i_dout_oe ? i_dout : 1'bx};
			#1;
		end
		#36;
		o_cs_n = 1'b1;
		// released data line shows the inverse, not a stale bit
		o_din = ~o_din;
		// return on the bench's stimulus phase, eight clocks after deselect
		repeat (8) @(posedge i_clk);
		#1;
	endtask
endmodule

// file: dv/testbench.sv
// self-checking bench for the octal switch serial control port
`timescale 1ns/10ps
module testbench;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic en = 1'b0;
	logic d5 = 1'b0;
	logic d6 = 1'b0;
	logic [7:0] fault = 8'h00;
	logic cs_n;
	logic sclk;
	logic din;
	logic dout;
	logic oe;
	logic [7:0] drive;
	logic [7:0] olc;
	logic sleep;
	logic ready;
	logic [15:0] rsp;
	int fail_count = 0;
	int total_checks = 0;
	int cycles = 0;
	always #4 i_clk = ~i_clk;
	ocs_host host (.i_clk(i_clk), .i_dout(dout), .i_dout_oe(oe),
		.o_cs_n(cs_n), .o_sclk(sclk), .o_din(din));
	ocs_serial_ctrl #(.DEPTH(2), .FAULT_CYC(20)) dut (.i_clk(i_clk),
		.i_rst(i_rst), .i_chip_sel_n(cs_n), .i_serial_clk(sclk),
		.i_serial_cmd_in(din), .i_enable(en),
		.i_direct_drive_five(d5), .i_direct_drive_six(d6),
		.i_fault_cond(fault), .o_serial_out(dout),
		.o_serial_out_oe(oe), .o_drive(drive), .o_olc_en(olc),
		.o_sleep(sleep), .o_cmd_ready(ready));
	task automatic complete_run();
		if (fail_count == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		total_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wait_clk(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	// two 100 us waits dominate; the whole run needs about 27000 cycles
	always @(posedge i_clk)
	begin
		cycles++;
		if (cycles >= 40000)
		begin
			fail_count++;
			complete_run();
		end
	end
	task automatic reset_and_wake();
		wait_clk(4);
		i_rst = 1'b0;
		chk("sleep", 16'h0001, 16'(sleep));
		chk("drive", 16'h0000, 16'(drive));
		chk("oe idle", 16'h0000, 16'(oe));
		en = 1'b1;
		// 100 us of quiet link before the first frame
		wait_clk(12500);
	endtask
	task automatic apply_command();
		host.xfer(16'h0fa5, 16, rsp);
		chk("drive early", 16'h0000, 16'(drive));
		chk("rsp clean", 16'h0000, rsp);
		wait_clk(100);
		chk("drive in delay", 16'h0000, 16'(drive));
		wait_clk(100);
		chk("drive", 16'h00a5, 16'(drive));
		chk("olc", 16'h000f, 16'(olc));
		chk("ready", 16'h0001, 16'(ready));
		chk("oe after", 16'h0000, 16'(oe));
	endtask
	task automatic fault_report();
		fault = 8'hc1;
		wait_clk(10);
		fault[0] = 1'b0;
		// qualify time is cut to 20 cycles here, access spacing with it
		wait_clk(70);
		host.xfer(16'h0fa5, 16, rsp);
		chk("fault rsp", 16'h0080, rsp);
		fault = 8'h00;
	endtask
	task automatic short_frame();
		host.xfer(16'h0000, 15, rsp);
		wait_clk(200);
		chk("short frame", 16'h00a5, 16'(drive));
	endtask
	task automatic direct_drive();
		d5 = 1'b1;
		d6 = 1'b1;
		wait_clk(8);
		chk("direct", 16'h00b5, 16'(drive));
		d5 = 1'b0;
		d6 = 1'b0;
		wait_clk(8);
		chk("direct off", 16'h00a5, 16'(drive));
	endtask
	task automatic back_to_back();
		host.xfer(16'h3c3c, 16, rsp);
		host.xfer(16'h00c3, 16, rsp);
		chk("b2b rsp", 16'h0000, rsp);
		chk("b2b first", 16'h003c, 16'(drive));
		chk("b2b first olc", 16'h003c, 16'(olc));
		wait_clk(300);
		chk("b2b drive", 16'h00c3, 16'(drive));
		chk("b2b olc", 16'h0000, 16'(olc));
	endtask
	task automatic sleep_wake();
		en = 1'b0;
		wait_clk(8);
		chk("sleep on", 16'h0001, 16'(sleep));
		chk("sleep drive", 16'h0000, 16'(drive));
		chk("sleep olc", 16'h0000, 16'(olc));
		// enable stays low 100 us so the wake is a full reset
		wait_clk(12500);
		en = 1'b1;
		wait_clk(20);
		chk("wake drive", 16'h0000, 16'(drive));
		chk("wake sleep", 16'h0000, 16'(sleep));
	endtask
	initial
	begin
		reset_and_wake();
		apply_command();
		fault_report();
		short_frame();
		direct_drive();
		back_to_back();
		sleep_wake();
		complete_run();
	end
endmodule
